// [ext_edge_irq_flags_priority.sv]
// Purpose: Interrupt flags, secondary priority and external edge sources
// Assumes: Core special-function bus with one-cycle read and write strobes
// Notes: Pins pass a two-stage synchroniser before the edge detectors
//
// Overview of operation
// R1: Bits 7:5 read zero, ignore writes
// R2: Priority bit 4 ranks spare source b
// R3: Priority bit 3 ranks spare source a
// R4: Priority bit 2 ranks frequency counter
// R5: Software keeps priority bits 1:0 zero
// R6: Spare flags set only by software
// R7: Serializer empty sets flag, hardware never clears
// R8: Software clears serializer flag before loading
// R9: Edge sets external flag regardless of enable
// R10: Vectoring never clears external pending flags
// R11: External sources are edge only, polarity selectable
// R12: Edge mode picks rising or both edges
// R13: Invert bits flip selected pin
// R14: Source b pin select codes
// R15: Source a pin select codes
// R16: Pins sampled by clock, short pulses missed
// R17: Detected events drive timer capture
// R18: External request needs enable and global enable
// R19: Previous sample compared, flag set next cycle
`timescale 1ns/10ps
`default_nettype none
module ext_edge_irq_flags_priority (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // Special-function register bus
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    // Port pins and controls kept elsewhere
    input wire logic [9:0] gpio_in,
    input wire logic ext_irq_b_double_edge_in,
    input wire logic ext_irq_a_double_edge_in,
    input wire logic ext_irq_b_enable_in,
    input wire logic ext_irq_a_enable_in,
    input wire logic global_irq_enable_in,
    input wire logic serializer_tx_empty_in,
    // Requests toward the vectoring logic
    output logic ext_irq_b_req_out,
    output logic ext_irq_a_req_out,
    output logic spare_irq_b_req_out,
    output logic spare_irq_a_req_out,
    output logic serializer_req_out,
    output logic spare_b_priority_out,
    output logic spare_a_priority_out,
    output logic freq_counter_priority_out,
    // Capture triggers for timers 3 and 2
    output logic timer3_capture_out,
    output logic timer2_capture_out
);
    logic [7:0] pin_config_q;
    logic [7:0] sec_prio_q;
    logic [4:0] flags_q;
    logic [4:0] flags_d;
    logic [9:0] gpio_meta_q;
    logic [9:0] gpio_sync_q;
    logic ser_empty_q;
    logic ser_empty_rise;
    logic ext_b_level;
    logic ext_a_level;
    logic ext_b_event;
    logic ext_a_event;
    logic wr_flags;

    // Two-stage synchroniser; only the second stage feeds any logic
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            gpio_meta_q <= 10'h000;
            gpio_sync_q <= 10'h000;
        end else if (clk_en_in) begin
            gpio_meta_q <= gpio_in; // see R16
            gpio_sync_q <= gpio_meta_q;
        end
    end

    // Pin choice and polarity for each source
    pin_select #(
        .ALT_PIN(irq_pkg::EXT_B_ALT_PIN)
    ) sel_b (
        .pins_in(gpio_sync_q),
        .sel_in(pin_config_q[irq_pkg::EXT_B_SEL_LSB +: 3]),
        .invert_in(pin_config_q[irq_pkg::EXT_B_INVERT_BIT]),
        .pin_out(ext_b_level)
    );

    pin_select #(
        .ALT_PIN(irq_pkg::EXT_A_ALT_PIN)
    ) sel_a (
        .pins_in(gpio_sync_q),
        .sel_in(pin_config_q[irq_pkg::EXT_A_SEL_LSB +: 3]),
        .invert_in(pin_config_q[irq_pkg::EXT_A_INVERT_BIT]),
        .pin_out(ext_a_level)
    );

    // Edge detectors; a change of pin select can itself look like an edge
    edge_detect det_b (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .level_in(ext_b_level),
        .double_edge_in(ext_irq_b_double_edge_in),
        .event_out(ext_b_event)
    );

    edge_detect det_a (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .level_in(ext_a_level),
        .double_edge_in(ext_irq_a_double_edge_in),
        .event_out(ext_a_event)
    );

    // Events also serve as timer capture strobes
    assign timer3_capture_out = ext_b_event; // see R17
    assign timer2_capture_out = ext_a_event; // see R17

    // Serializer empty is a same-clock level; flag on its rising edge
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ser_empty_q <= 1'h0;
        end else if (clk_en_in) begin
            ser_empty_q <= serializer_tx_empty_in;
        end
    end
    assign ser_empty_rise = serializer_tx_empty_in & ~ser_empty_q;

    // Pin configuration register
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_config_q <= irq_pkg::PIN_CONFIG_RESET;
        end else if (clk_en_in && sfr_wr_in &&
                     sfr_addr_in == irq_pkg::PIN_CONFIG_ADDR) begin
            pin_config_q <= sfr_wdata_in; // see R13 see R14 see R15
        end
    end

    // Secondary priority; bits 1:0 stored as written, software keeps zero
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sec_prio_q <= irq_pkg::SEC_PRIO_RESET;
        end else if (clk_en_in && sfr_wr_in &&
                     sfr_addr_in == irq_pkg::SEC_PRIO_ADDR) begin
            sec_prio_q <= sfr_wdata_in & irq_pkg::SEC_PRIO_MASK; // see R1
        end
    end

    // Priority levels go straight to the vectoring logic
    assign spare_b_priority_out =
        sec_prio_q[irq_pkg::SPARE_B_PRIO_BIT]; // see R2
    assign spare_a_priority_out =
        sec_prio_q[irq_pkg::SPARE_A_PRIO_BIT]; // see R3
    assign freq_counter_priority_out =
        sec_prio_q[irq_pkg::FREQ_PRIO_BIT]; // see R4

    assign wr_flags = sfr_wr_in && (sfr_addr_in == irq_pkg::FLAGS_ADDR);

    // Flags: a write stores the value, hardware events win over a clear
    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d = sfr_wdata_in[4:0]; // see R6 see R1
        end
        if (ser_empty_rise) begin
            flags_d[irq_pkg::SER_FLAG_BIT] = 1'h1; // see R7
        end
        if (ext_b_event) begin
            flags_d[irq_pkg::EXT_B_FLAG_BIT] = 1'h1; // see R9 see R19
        end
        if (ext_a_event) begin
            flags_d[irq_pkg::EXT_A_FLAG_BIT] = 1'h1; // see R9 see R19
        end
    end

    // No vectoring input exists here, so pending flags are never auto-cleared
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_q <= irq_pkg::FLAGS_RESET[4:0];
        end else if (clk_en_in) begin
            flags_q <= flags_d; // see R10
        end
    end

    // Requests to the core
    assign ext_irq_b_req_out = flags_q[irq_pkg::EXT_B_FLAG_BIT] &
        ext_irq_b_enable_in & global_irq_enable_in; // see R18
    assign ext_irq_a_req_out = flags_q[irq_pkg::EXT_A_FLAG_BIT] &
        ext_irq_a_enable_in & global_irq_enable_in; // see R18
    assign spare_irq_b_req_out = flags_q[irq_pkg::SPARE_B_FLAG_BIT]; // see R6
    assign spare_irq_a_req_out = flags_q[irq_pkg::SPARE_A_FLAG_BIT]; // see R6
    assign serializer_req_out = flags_q[irq_pkg::SER_FLAG_BIT];

    // Read mux; unmapped addresses return zero and no hit
    always_comb begin
        sfr_rdata_out = 8'h00;
        sfr_hit_out = 1'h0;
        if (sfr_addr_in == irq_pkg::PIN_CONFIG_ADDR) begin
            sfr_rdata_out = pin_config_q;
            sfr_hit_out = 1'h1;
        end else if (sfr_addr_in == irq_pkg::FLAGS_ADDR) begin
            sfr_rdata_out = {3'h0, flags_q}; // see R1
            sfr_hit_out = 1'h1;
        end else if (sfr_addr_in == irq_pkg::SEC_PRIO_ADDR) begin
            sfr_rdata_out = sec_prio_q & irq_pkg::SEC_PRIO_MASK; // see R1
            sfr_hit_out = 1'h1;
        end
    end

    // Upper bits of the masked priority register stay zero
    reserved_zero_a: assert property ( // see R1
        @(posedge sys_clk_in) disable iff (rst_in)
        sec_prio_q[7:5] == 3'h0)
        else $error("priority reserved bits set");

    // Reserved flag bits read back as zero
    flags_read_zero_a: assert property ( // see R1
        @(posedge sys_clk_in) disable iff (rst_in)
        sfr_addr_in == irq_pkg::FLAGS_ADDR |-> sfr_rdata_out[7:5] == 3'h0)
        else $error("flag reserved bits read nonzero");

    // Reserved priority bits read back as zero
    prio_read_zero_a: assert property ( // see R1
        @(posedge sys_clk_in) disable iff (rst_in)
        sfr_addr_in == irq_pkg::SEC_PRIO_ADDR |->
        sfr_rdata_out[7:5] == 3'h0)
        else $error("priority reserved bits read nonzero");

    // A detected edge on source a sets its flag at the next edge
    edge_sets_flag_a: assert property ( // see R19
        @(posedge sys_clk_in) disable iff (rst_in)
        ext_a_event |=> flags_q[irq_pkg::EXT_A_FLAG_BIT])
        else $error("edge did not set flag a");

    // Same for source b; a clear in that cycle must lose
    edge_sets_b_a: assert property ( // see R19
        @(posedge sys_clk_in) disable iff (rst_in)
        ext_b_event |=> flags_q[irq_pkg::EXT_B_FLAG_BIT])
        else $error("edge did not set flag b");

    // Flag a rises only through its event or a register write
    ext_flag_src_a: assert property ( // see R9
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(flags_q[irq_pkg::EXT_A_FLAG_BIT]) |->
        $past(ext_a_event) || $past(wr_flags))
        else $error("flag a rose without cause");

    // Flag b rises only through its event or a register write
    ext_src_b_a: assert property ( // see R9
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(flags_q[irq_pkg::EXT_B_FLAG_BIT]) |->
        $past(ext_b_event) || $past(wr_flags))
        else $error("flag b rose without cause");

    // Hardware never drops a pending flag of source a
    flag_hold_a: assert property ( // see R10
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(flags_q[irq_pkg::EXT_A_FLAG_BIT]) |-> $past(wr_flags))
        else $error("flag a cleared by hardware");

    // Hardware never drops a pending flag of source b
    flag_hold_b_a: assert property ( // see R10
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(flags_q[irq_pkg::EXT_B_FLAG_BIT]) |-> $past(wr_flags))
        else $error("flag b cleared by hardware");

    // Serializer flag never falls without software write
    ser_flag_hold_a: assert property ( // see R7
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(flags_q[irq_pkg::SER_FLAG_BIT]) |-> $past(wr_flags))
        else $error("serializer flag cleared by hardware");

    // Empty level rising sets the serializer flag, clear or not
    ser_flag_set_a: assert property ( // see R7
        @(posedge sys_clk_in) disable iff (rst_in)
        ser_empty_rise && clk_en_in |=> flags_q[irq_pkg::SER_FLAG_BIT])
        else $error("serializer flag not set");

    // Spare flag b rises only through a write of one
    spare_write_a: assert property ( // see R6
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(flags_q[irq_pkg::SPARE_B_FLAG_BIT]) |->
        $past(wr_flags && sfr_wdata_in[irq_pkg::SPARE_B_FLAG_BIT]))
        else $error("spare flag b set without write");

    // Spare flag a rises only through a write of one
    spare_a_write_a: assert property ( // see R6
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(flags_q[irq_pkg::SPARE_A_FLAG_BIT]) |->
        $past(wr_flags && sfr_wdata_in[irq_pkg::SPARE_A_FLAG_BIT]))
        else $error("spare flag a set without write");

    // Request b is exactly the flag gated by both enables
    ext_req_gate_a: assert property ( // see R18
        @(posedge sys_clk_in) disable iff (rst_in)
        ext_irq_b_req_out == (global_irq_enable_in && ext_irq_b_enable_in
        && flags_q[irq_pkg::EXT_B_FLAG_BIT]))
        else $error("request b does not follow enables");

    // Request a is exactly the flag gated by both enables
    req_gate_src_a: assert property ( // see R18
        @(posedge sys_clk_in) disable iff (rst_in)
        ext_irq_a_req_out == (global_irq_enable_in && ext_irq_a_enable_in
        && flags_q[irq_pkg::EXT_A_FLAG_BIT]))
        else $error("request a does not follow enables");

    // A level held over a running cycle never fires the detector
    no_level_fire_a: assert property ( // see R11
        @(posedge sys_clk_in) disable iff (rst_in)
        clk_en_in && $past(clk_en_in) && $stable(ext_a_level) |->
        !ext_a_event)
        else $error("steady level fired source a");

    // Single mode gives one-cycle capture strobes, never two in a row
    single_pulse_a: assert property ( // see R12
        @(posedge sys_clk_in) disable iff (rst_in)
        timer2_capture_out && !ext_irq_a_double_edge_in |=>
        !timer2_capture_out || ext_irq_a_double_edge_in)
        else $error("capture strobe a held in single mode");

    // Priority output b tracks the written bit
    prio_track_a: assert property ( // see R2
        @(posedge sys_clk_in) disable iff (rst_in)
        clk_en_in && sfr_wr_in && sfr_addr_in == irq_pkg::SEC_PRIO_ADDR |=>
        spare_b_priority_out == $past(sfr_wdata_in[4]))
        else $error("priority b not updated");

    // Priority output a tracks the written bit
    spare_a_prio_a: assert property ( // see R3
        @(posedge sys_clk_in) disable iff (rst_in)
        clk_en_in && sfr_wr_in && sfr_addr_in == irq_pkg::SEC_PRIO_ADDR |=>
        spare_a_priority_out == $past(sfr_wdata_in[3]))
        else $error("priority a not updated");

    // Frequency counter priority tracks the written bit
    freq_prio_a: assert property ( // see R4
        @(posedge sys_clk_in) disable iff (rst_in)
        clk_en_in && sfr_wr_in && sfr_addr_in == irq_pkg::SEC_PRIO_ADDR |=>
        freq_counter_priority_out == $past(sfr_wdata_in[2]))
        else $error("frequency priority not updated");

    // A low clock enable freezes every register
    frozen_hold_a: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !clk_en_in |=> $stable(flags_q) && $stable(pin_config_q)
        && $stable(sec_prio_q))
        else $error("state changed while frozen");
endmodule : ext_edge_irq_flags_priority
`default_nettype wire

// [irq_pkg.sv]
// Purpose: Shared constants for the external edge interrupt and flag block
// Assumes: 8-bit special-function register bus, 20 MHz system clock
// Notes: Offsets are special-function register addresses
`default_nettype none
package irq_pkg;
    localparam logic [7:0] PIN_CONFIG_ADDR = 8'hB7;
    localparam logic [7:0] FLAGS_ADDR = 8'hBF;
    localparam logic [7:0] SEC_PRIO_ADDR = 8'hF6;
    localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] SEC_PRIO_RESET = 8'h00;
    // Implemented bits of the priority and flag registers
    localparam logic [7:0] SEC_PRIO_MASK = 8'h1F;
    localparam logic [7:0] FLAGS_MASK = 8'h1F;
    // Secondary priority fields
    localparam int SPARE_B_PRIO_BIT = 4;
    localparam int SPARE_A_PRIO_BIT = 3;
    localparam int FREQ_PRIO_BIT = 2;
    // Flag fields
    localparam int SPARE_B_FLAG_BIT = 4;
    localparam int SPARE_A_FLAG_BIT = 3;
    localparam int SER_FLAG_BIT = 2;
    localparam int EXT_B_FLAG_BIT = 1;
    localparam int EXT_A_FLAG_BIT = 0;
    // Pin configuration fields
    localparam int EXT_B_INVERT_BIT = 7;
    localparam int EXT_B_SEL_LSB = 4;
    localparam int EXT_A_INVERT_BIT = 3;
    localparam int EXT_A_SEL_LSB = 0;
    localparam int PIN_COUNT = 10;
    // Pin numbers for select code 101, per source
    localparam logic [3:0] EXT_B_ALT_PIN = 4'h9;
    localparam logic [3:0] EXT_A_ALT_PIN = 4'h8;
    // Shortest pulse that is sure to be caught, in system clocks
    localparam int MIN_PULSE_CYCLES = 2;
endpackage : irq_pkg
`default_nettype wire

// [pin_select.sv]
// Purpose: Picks one pin for an external source and applies polarity
// Assumes: Pins already synchronised to the system clock
// Notes: Combinational only
`timescale 1ns/10ps
`default_nettype none
module pin_select #(
    parameter logic [3:0] ALT_PIN = 4'h8
) (
    input wire logic [9:0] pins_in,
    input wire logic [2:0] sel_in,
    input wire logic invert_in,
    output logic pin_out
);
    logic [3:0] idx;

    // Codes 0..4 map straight, 5 goes to the alternate pin, 6 and 7 direct
    always_comb begin
        if (sel_in == 3'h5) begin
            idx = ALT_PIN; // see R14 see R15
        end else begin
            idx = {1'h0, sel_in};
        end
        pin_out = pins_in[idx] ^ invert_in; // see R13
    end
endmodule : pin_select
`default_nettype wire

// [edge_detect.sv]
// Purpose: Rising or double edge detector on a sampled level
// Assumes: Input is synchronous to sys_clk_in
// Notes: Pulse output is one cycle wide
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic level_in,
    input wire logic double_edge_in,
    output logic event_out
);
    logic prev_q;

    // Previous sample, held for comparison next cycle
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_q <= 1'h0;
        end else if (clk_en_in) begin
            prev_q <= level_in; // see R19
        end
    end

    // Only transitions count, never a steady level
    always_comb begin
        if (double_edge_in) begin
            event_out = clk_en_in & (level_in ^ prev_q); // see R12 see R11
        end else begin
            event_out = clk_en_in & level_in & ~prev_q; // see R12 see R11
        end
    end
endmodule : edge_detect
`default_nettype wire

// [core_model.sv]
// Purpose: Processor core model driving the register bus
// Assumes: One access at a time, launched just after a rising edge
// Notes: Released write data is inverted so stale values never match
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    // Bus idles with no strobe at time zero
    initial begin
        addr_out = 8'h80;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // Strobe stands one cycle; the write is taken at the next edge
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        wdata_out <= (a == 8'hF6) ? (d & 8'hFC) : d;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask : write
    // Read data is taken at the closing edge, while the address stands
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        d = rdata_in;
        rd_out <= 1'b0;
    endtask : read
endmodule : core_model
`default_nettype wire

// [ext_edge_irq_flags_priority_bench.sv]
// Purpose: Self-checking bench for flags, priority and edge sources
// Assumes: Core model drives the register bus
// Notes: Flags are cleared after each reconfiguration, which may glitch
`timescale 1ns/10ps
`default_nettype none
module ext_edge_irq_flags_priority_bench;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
    logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
    logic sfr_wr_in, sfr_rd_in, sfr_hit_out;
    logic [9:0] gpio_in = 10'h000;
    logic ext_irq_b_double_edge_in = 1'b0, ext_irq_a_double_edge_in = 1'b0;
    logic ext_irq_b_enable_in = 1'b1, ext_irq_a_enable_in = 1'b1;
    logic global_irq_enable_in = 1'b1, serializer_tx_empty_in = 1'b0;
    logic ext_irq_b_req_out, ext_irq_a_req_out, spare_irq_b_req_out;
    logic spare_irq_a_req_out, serializer_req_out, spare_b_priority_out;
    logic spare_a_priority_out, freq_counter_priority_out;
    logic timer3_capture_out, timer2_capture_out, sb = 1'b0, cap, req;
    logic [7:0] prio;
    int error_cnt = 0, tests_run = 0;
    // Views of the source under test
    assign cap = sb ? timer3_capture_out : timer2_capture_out;
    assign req = sb ? ext_irq_b_req_out : ext_irq_a_req_out;
    assign prio = {5'h00, spare_b_priority_out, spare_a_priority_out,
                   freq_counter_priority_out};
    always #25 sys_clk_in = ~sys_clk_in;
    core_model i_core_model (.sys_clk_in, .rdata_in(sfr_rdata_out),
        .addr_out(sfr_addr_in), .wdata_out(sfr_wdata_in),
        .wr_out(sfr_wr_in), .rd_out(sfr_rd_in));
    ext_edge_irq_flags_priority i_ext_edge_irq_flags_priority (
        .sys_clk_in, .rst_in, .clk_en_in, .sfr_addr_in, .sfr_wdata_in,
        .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .sfr_hit_out, .gpio_in,
        .ext_irq_b_double_edge_in, .ext_irq_a_double_edge_in,
        .ext_irq_b_enable_in, .ext_irq_a_enable_in, .global_irq_enable_in,
        .serializer_tx_empty_in, .ext_irq_b_req_out, .ext_irq_a_req_out,
        .spare_irq_b_req_out, .spare_irq_a_req_out, .serializer_req_out,
        .spare_b_priority_out, .spare_a_priority_out,
        .freq_counter_priority_out, .timer3_capture_out, .timer2_capture_out);
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_core_model.write(a, d);
    endtask : wr
    // Masked register read against an expected value
    task automatic rc(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e, input string n);
        logic [7:0] v;
        i_core_model.read(a, v);
        chk(n, e, v & m);
    endtask : rc
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic t_reset();
        rc(8'hB7, 8'hFF, 8'h00, "config");
        chk("hit on", 8'h01, {7'h00, sfr_hit_out});
        rc(8'hBF, 8'hFF, 8'h00, "flags");
        rc(8'hF6, 8'hFF, 8'h00, "priority");
        rc(8'h80, 8'hFF, 8'h00, "unmapped");
        chk("hit", 8'h00, {7'h00, sfr_hit_out});
        $display("reset test done");
    endtask : t_reset
    // One priority bit at a time, reserved bits written high
    task automatic t_prio();
        for (int b = 2; b < 5; b++) begin
            wr(8'hF6, 8'hE0 | (8'h01 << b));
            @(negedge sys_clk_in);
            chk("prio out", 8'h01 << (b - 2), prio);
            rc(8'hF6, 8'hFF, 8'h01 << b, "priority");
        end
        $display("priority test done");
    endtask : t_prio
    // Spare flags by software; a frozen clock must ignore the write
    task automatic t_flags();
        wr(8'hBF, 8'hF8);
        rc(8'hBF, 8'hFF, 8'h18, "flags");
        chk("spare req", 8'h03,
            {6'h00, spare_irq_b_req_out, spare_irq_a_req_out});
        clk_en_in <= 1'b0;
        wr(8'hBF, 8'h00);
        clk_en_in <= 1'b1;
        rc(8'hBF, 8'hFF, 8'h18, "frozen");
        wr(8'hBF, 8'h00);
        rc(8'hBF, 8'hFF, 8'h00, "cleared");
        $display("flag test done");
    endtask : t_flags
    // Empty flag outlives its level; software clears it before a new byte
    task automatic t_serial();
        @(posedge sys_clk_in);
        serializer_tx_empty_in <= 1'b1;
        repeat (20) @(posedge sys_clk_in);
        serializer_tx_empty_in <= 1'b0;
        rc(8'hBF, 8'hFF, 8'h04, "tx empty");
        chk("ser req", 8'h01, {7'h00, serializer_req_out});
        wr(8'hBF, 8'h00);
        rc(8'hBF, 8'hFF, 8'h00, "tx cleared");
        $display("serializer test done");
    endtask : t_serial
    // Configure a source, settle, clear glitches, then move its pin once
    task automatic t_edge(input logic s, input logic [2:0] sel,
        input int pin, input logic inv, dbl, up, ex);
        logic seen;
        logic [7:0] m;
        m = s ? 8'h02 : 8'h01;
        seen = 1'b0;
        @(posedge sys_clk_in);
        sb <= s;
        gpio_in <= up ? 10'h000 : 10'h3FF;
        ext_irq_b_double_edge_in <= dbl;
        ext_irq_a_double_edge_in <= dbl;
        wr(8'hB7, s ? {inv, sel, 4'h0} : {4'h0, inv, sel});
        repeat (4) @(posedge sys_clk_in);
        wr(8'hBF, 8'h00);
        gpio_in[pin] <= up;
        for (int n = 0; n < 6 && !seen; n++) begin
            @(negedge sys_clk_in);
            seen = (cap === 1'b1);
        end
        chk("capture", {7'h00, ex}, {7'h00, seen});
        if (ex && !seen) begin
            end_of_test();
        end
        if (seen) begin
            chk("flag early", 8'h00, {7'h00, req});
            @(negedge sys_clk_in);
            chk("flag", 8'h01, {7'h00, req});
            chk("pulse", 8'h00, {7'h00, cap});
        end
        rc(8'hBF, m, ex ? m : 8'h00, "ext flag");
        $display("edge test done");
    endtask : t_edge
    // Flag sets while masked, persists, and gating follows both enables
    task automatic t_gate();
        @(posedge sys_clk_in);
        sb <= 1'b0;
        ext_irq_a_enable_in <= 1'b0;
        gpio_in <= 10'h000;
        wr(8'hB7, 8'h02);
        repeat (4) @(posedge sys_clk_in);
        wr(8'hBF, 8'h00);
        gpio_in[2] <= 1'b1;
        repeat (40) @(posedge sys_clk_in);
        chk("masked req", 8'h00, {7'h00, req});
        rc(8'hBF, 8'h01, 8'h01, "set masked");
        ext_irq_a_enable_in <= 1'b1;
        global_irq_enable_in <= 1'b0;
        @(negedge sys_clk_in);
        chk("global off", 8'h00, {7'h00, req});
        @(posedge sys_clk_in);
        global_irq_enable_in <= 1'b1;
        @(negedge sys_clk_in);
        chk("req on", 8'h01, {7'h00, req});
        $display("gate test done");
    endtask : t_gate
    // Main sequence: reset for two cycles, then every scenario
    initial begin
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_prio();
        t_flags();
        t_serial();
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 8; c++) begin
                t_edge(s[0], c[2:0], (c == 5) ? 8 + s : c,
                       1'b0, 1'b0, 1'b1, 1'b1);
            end
        end
        t_edge(1'b0, 3'h2, 2, 1'b0, 1'b0, 1'b0, 1'b0);
        t_edge(1'b1, 3'h3, 3, 1'b0, 1'b1, 1'b0, 1'b1);
        t_edge(1'b0, 3'h6, 6, 1'b1, 1'b0, 1'b0, 1'b1);
        t_edge(1'b1, 3'h7, 7, 1'b1, 1'b0, 1'b1, 1'b0);
        t_gate();
        end_of_test();
    end
endmodule : ext_edge_irq_flags_priority_bench
`default_nettype wire
